//--- rtl/cmsl_pkg.sv
// Shared constants and types for the configuration mode-select loader
package cmsl_pkg;
   localparam int MODE_W = 3;
   typedef enum logic [2:0]
   {
      CMSL_MODE_SER_MASTER  = 3'h0,
      CMSL_MODE_RSV_A       = 3'h1,
      CMSL_MODE_RSV_B       = 3'h2,
      CMSL_MODE_SYNC_PERIPH = 3'h3,
      CMSL_MODE_PAR_UP      = 3'h4,
      CMSL_MODE_ASYNC_PERIPH = 3'h5,
      CMSL_MODE_PAR_DOWN    = 3'h6,
      CMSL_MODE_SER_SLAVE   = 3'h7
   } cmsl_mode_t;
   localparam int ADDR_W = 22;
   localparam logic [21:0] ADDR_UP_START   = 22'h000000;
   localparam logic [21:0] ADDR_DOWN_18    = 22'h03FFFF;
   localparam logic [21:0] ADDR_DOWN_22    = 22'h3FFFFF;
   localparam int CLK_HZ       = 10_000_000;
   localparam int CONFIG_CLOCK_SLOW_HZ = 1_000_000;
   localparam int CONFIG_CLOCK_FAST_HZ = 8_000_000;
   // Half periods of the generated clock in system cycles, rounded down, at least one
   localparam int SLOW_HALF = (CLK_HZ / (2 * CONFIG_CLOCK_SLOW_HZ)) < 1 ? 1 : CLK_HZ / (2 * CONFIG_CLOCK_SLOW_HZ);
   localparam int FAST_HALF = (CLK_HZ / (2 * CONFIG_CLOCK_FAST_HZ)) < 1 ? 1 : CLK_HZ / (2 * CONFIG_CLOCK_FAST_HZ);
   // Register byte addresses
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_DATA   = 8'h08;
   localparam logic [7:0] REG_COUNT  = 8'h0C;
   localparam logic [7:0] REG_AUX    = 8'h10;
   // Control fields
   localparam int CTRL_START  = 0;
   localparam int CTRL_FAST   = 1;
   localparam int CTRL_LINES22 = 2;
   localparam int CTRL_LOWV   = 3;
   localparam int CTRL_AUXEN  = 4;
   localparam int CTRL_ABORT  = 5;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cmsl_pkg

//--- rtl/cmsl_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module cmsl_sync #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;

   always_comb
   begin
      meta_nxt = d;
      q_nxt    = meta_r;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else
      begin
         meta_r <= meta_nxt;
         q      <= q_nxt;
      end
   end
endmodule : cmsl_sync

//--- rtl/cmsl_clkdiv.sv
// Enable-pulse divider making the generated configuration clock level
`timescale 1ns/1ps
module cmsl_clkdiv #(
   parameter int SLOW = 5,
   parameter int FAST = 1
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic run,
   input  wire logic fast,
   output logic      rise,
   output logic      fall,
   output logic      level
);
   localparam int CW = $clog2(SLOW + 1);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          lvl_r;
   logic          lvl_nxt;
   logic [CW-1:0] half;

   initial
   begin
      if (SLOW < 1 || FAST < 1 || FAST > SLOW)
         $error("cmsl_clkdiv: bad half periods");
   end

   always_comb
   begin
      half    = fast ? CW'(FAST) : CW'(SLOW);
      cnt_nxt = cnt_r;
      lvl_nxt = lvl_r;
      rise    = 1'b0;
      fall    = 1'b0;
      if (!run)
      begin
         cnt_nxt = '0;
         lvl_nxt = 1'b0;
      end
      else if (cnt_r + CW'(1) >= half)
      begin
         cnt_nxt = '0;
         lvl_nxt = !lvl_r;
         rise    = !lvl_r;
         fall    = lvl_r;
      end
      else
         cnt_nxt = cnt_r + CW'(1);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_r <= '0;
         lvl_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         lvl_r <= lvl_nxt;
      end
   end

   assign level = lvl_r;
endmodule : cmsl_clkdiv

//--- rtl/cmsl_loader.sv
// Configuration mode-select loader: mode capture, master and peripheral data paths
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module cmsl_loader #(
   parameter int          FRAME_BITS = 64,
   parameter logic [31:0] LOAD_BITS  = 32'h0000_0400
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        mode_sel_bit2,
   input  wire logic        mode_sel_bit1,
   input  wire logic        mode_sel_bit0,
   input  wire logic        config_clock_in,
   output logic             config_clock_out,
   output logic             config_clock_oe,
   input  wire logic        serial_data_in,
   output logic             serial_data_out,
   input  wire logic [7:0]  prom_data,
   output logic [17:0]      prom_address,
   output logic [3:0]       upper_prom_address,
   output logic             prom_address_oe,
   output logic             upper_prom_address_oe,
   input  wire logic [7:0]  host_data,
   input  wire logic        host_write_n,
   output logic             ready_busy,
   output logic             aux_output_pad,
   output logic             aux_output_oe,
   output logic             config_bit,
   output logic             config_bit_valid
);
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_LOAD = 3'h1,
      ST_DONE = 3'h3,
      ST_HALT = 3'h2
   } cmsl_state_t;

   initial
   begin
      if (FRAME_BITS < 1)
         $error("cmsl_loader: FRAME_BITS must be positive");
   end

   function automatic logic is_reserved(input logic [2:0] m);
      is_reserved = (m == 3'h1) || (m == 3'h2);
   endfunction : is_reserved

   function automatic logic is_master(input logic [2:0] m);
      is_master = (m == 3'h0) || (m == 3'h4) || (m == 3'h6);
   endfunction : is_master

   // Synchronised pins
   logic [2:0] mode_s;
   logic [1:0] lnk_s;
   logic       wr_n_s;
   cmsl_sync #(.W(3)) u_mode_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({mode_sel_bit2, mode_sel_bit1, mode_sel_bit0}),
      .q       (mode_s)
   );
   cmsl_sync #(.W(3)) u_link_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({config_clock_in, serial_data_in, host_write_n}),
      .q       ({lnk_s, wr_n_s})
   );

   // Registers
   cmsl_state_t st_r, st_nxt;
   logic [5:0]  ctrl_r, ctrl_nxt;
   logic [2:0]  mode_r, mode_nxt;
   logic [21:0] addr_r, addr_nxt;
   logic [7:0]  shf_r, shf_nxt;
   logic [3:0]  bcnt_r, bcnt_nxt;
   logic [31:0] tot_r, tot_nxt;
   logic        fast_r, fast_nxt;
   logic        lines22_r, lines22_nxt;
   logic        busy_r, busy_nxt;
   logic        ext_prev_r, ext_prev_nxt;
   logic        wr_prev_r, wr_prev_nxt;
   logic        fwd_r, fwd_nxt;
   logic        dout_r, dout_nxt;
   logic        cbit_r, cbit_nxt;
   logic        cval_r, cval_nxt;
   logic        aux_r, aux_nxt;
   logic [7:0]  hbyte_r, hbyte_nxt;
   logic        aw_r, aw_nxt;
   logic        w_r, w_nxt;
   logic [7:0]  awa_r, awa_nxt;
   logic [31:0] wd_r, wd_nxt;
   logic        bv_r, bv_nxt;
   logic [1:0]  br_r, br_nxt;
   logic        rv_r, rv_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic [1:0]  rr_r, rr_nxt;
   logic        cko_r, cko_nxt;
   logic        ckoe_r, ckoe_nxt;
   logic        aoe_r, aoe_nxt;
   logic        uoe_r, uoe_nxt;

   // Generated clock runs during load in master modes, and in async peripheral mode only while a byte is busy
   logic gen_run;
   logic g_rise;
   logic g_fall;
   logic g_lvl;
   cmsl_clkdiv #(.SLOW(cmsl_pkg::SLOW_HALF), .FAST(cmsl_pkg::FAST_HALF)) u_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (gen_run),
      .fast    (fast_r),
      .rise    (g_rise),
      .fall    (g_fall),
      .level   (g_lvl)
   );

   logic ext_rise;
   logic ext_fall;
   logic c_rise;
   logic c_fall;
   logic host_wr;
   logic bit_in;
   logic load_bit;

   always_comb
   begin
      ext_rise = lnk_s[1] && !ext_prev_r;
      ext_fall = !lnk_s[1] && ext_prev_r;
      host_wr  = !wr_n_s && wr_prev_r;
      gen_run  = (st_r == ST_LOAD) && (is_master(mode_r) ||
                 (mode_r == cmsl_pkg::CMSL_MODE_ASYNC_PERIPH && busy_r));
      c_rise   = gen_run ? g_rise : (st_r == ST_LOAD && !is_master(mode_r) && ext_rise);
      c_fall   = gen_run ? g_fall : (!is_master(mode_r) && ext_fall);
      // Data bit source per mode
      unique case (mode_r)
         cmsl_pkg::CMSL_MODE_SER_MASTER,
         cmsl_pkg::CMSL_MODE_SER_SLAVE:  bit_in = lnk_s[0];
         cmsl_pkg::CMSL_MODE_PAR_UP,
         cmsl_pkg::CMSL_MODE_PAR_DOWN:   bit_in = prom_data[bcnt_r[2:0]];
         default:                        bit_in = hbyte_r[bcnt_r[2:0]];
      endcase
      load_bit = c_rise && (is_master(mode_r) && mode_r != cmsl_pkg::CMSL_MODE_SER_MASTER
                 || mode_r == cmsl_pkg::CMSL_MODE_SER_MASTER
                 || mode_r == cmsl_pkg::CMSL_MODE_SER_SLAVE || busy_r);
   end

   // Configuration state group
   always_comb
   begin
      st_nxt       = st_r;
      mode_nxt     = mode_r;
      addr_nxt     = addr_r;
      shf_nxt      = shf_r;
      bcnt_nxt     = bcnt_r;
      tot_nxt      = tot_r;
      fast_nxt     = fast_r;
      lines22_nxt  = lines22_r;
      busy_nxt     = busy_r;
      ext_prev_nxt = lnk_s[1];
      wr_prev_nxt  = wr_n_s;
      fwd_nxt      = fwd_r;
      dout_nxt     = dout_r;
      cbit_nxt     = cbit_r;
      cval_nxt     = 1'b0;
      hbyte_nxt    = hbyte_r;
      aux_nxt      = aux_r;
      unique case (st_r)
         ST_IDLE:
         begin
            if (ctrl_r[cmsl_pkg::CTRL_START])
            begin
               mode_nxt = mode_s;
               if (is_reserved(mode_s))
                  st_nxt = ST_HALT;
               else
               begin
                  st_nxt      = ST_LOAD;
                  fast_nxt    = 1'b0;
                  lines22_nxt = ctrl_r[cmsl_pkg::CTRL_LINES22]
                                || ctrl_r[cmsl_pkg::CTRL_LOWV];
                  addr_nxt    = cmsl_pkg::ADDR_UP_START;
                  if (mode_s == cmsl_pkg::CMSL_MODE_PAR_DOWN)
                     addr_nxt = lines22_nxt ? cmsl_pkg::ADDR_DOWN_22
                                            : cmsl_pkg::ADDR_DOWN_18;
                  bcnt_nxt = '0;
                  tot_nxt  = '0;
                  busy_nxt = 1'b0;
               end
            end
         end
         ST_LOAD:
         begin
            if (ctrl_r[cmsl_pkg::CTRL_ABORT])
               st_nxt = ST_IDLE;
            // Peripheral byte accept
            if ((mode_r == cmsl_pkg::CMSL_MODE_SYNC_PERIPH
                 || mode_r == cmsl_pkg::CMSL_MODE_ASYNC_PERIPH) && host_wr && !busy_r)
            begin
               hbyte_nxt = host_data;
               busy_nxt  = 1'b1;
               bcnt_nxt  = '0;
            end
            if (load_bit)
            begin
               shf_nxt  = {bit_in, shf_r[7:1]};
               cbit_nxt = bit_in;
               cval_nxt = 1'b1;
               fwd_nxt  = shf_r[7];
               tot_nxt  = tot_r + 32'h1;
               if (tot_r == 32'(FRAME_BITS) && ctrl_r[cmsl_pkg::CTRL_FAST])
                  fast_nxt = 1'b1;
               if (mode_r != cmsl_pkg::CMSL_MODE_SER_MASTER
                   && mode_r != cmsl_pkg::CMSL_MODE_SER_SLAVE)
               begin
                  bcnt_nxt = bcnt_r + 4'h1;
                  if (bcnt_r == 4'h7)
                  begin
                     bcnt_nxt = '0;
                     busy_nxt = 1'b0;
                     if (mode_r == cmsl_pkg::CMSL_MODE_PAR_UP)
                        addr_nxt = addr_r + 22'h1;
                     else if (mode_r == cmsl_pkg::CMSL_MODE_PAR_DOWN)
                        addr_nxt = addr_r - 22'h1;
                  end
               end
               if (tot_r + 32'h1 >= LOAD_BITS)
                  st_nxt = ST_DONE;
            end
            if (c_fall)
               dout_nxt = fwd_r;
         end
         ST_DONE:
         begin
            busy_nxt = 1'b0;
            if (c_fall)
               dout_nxt = lnk_s[0];
            aux_nxt = mode_s[2] ^ mode_s[0];
            if (ctrl_r[cmsl_pkg::CTRL_ABORT])
               st_nxt = ST_IDLE;
         end
         ST_HALT:
         begin
            if (ctrl_r[cmsl_pkg::CTRL_ABORT])
               st_nxt = ST_IDLE;
         end
      endcase
      ckoe_nxt = gen_run;
      cko_nxt  = gen_run && g_lvl;
      aoe_nxt  = (st_r == ST_LOAD) && (mode_r == cmsl_pkg::CMSL_MODE_PAR_UP
                 || mode_r == cmsl_pkg::CMSL_MODE_PAR_DOWN);
      uoe_nxt  = aoe_nxt && lines22_r;
   end

   // Bus slave group
   logic aw_take;
   logic w_take;
   always_comb
   begin
      aw_take = s_axi_awvalid && !aw_r && !bv_r;
      w_take  = s_axi_wvalid && !w_r && !bv_r;
      aw_nxt  = aw_r || aw_take;
      w_nxt   = w_r || w_take;
      awa_nxt = aw_take ? s_axi_awaddr[7:0] : awa_r;
      wd_nxt  = w_take ? s_axi_wdata : wd_r;
      bv_nxt  = bv_r && !s_axi_bready;
      br_nxt  = br_r;
      ctrl_nxt = ctrl_r;
      ctrl_nxt[cmsl_pkg::CTRL_START] = 1'b0;
      ctrl_nxt[cmsl_pkg::CTRL_ABORT] = 1'b0;
      if (aw_r && w_r)
      begin
         aw_nxt = 1'b0;
         w_nxt  = 1'b0;
         bv_nxt = 1'b1;
         br_nxt = cmsl_pkg::RESP_OKAY;
         if (awa_r == cmsl_pkg::REG_CTRL && s_axi_wstrb[0])
            ctrl_nxt = wd_r[5:0];
         else if (awa_r != cmsl_pkg::REG_STATUS && awa_r != cmsl_pkg::REG_DATA
                  && awa_r != cmsl_pkg::REG_COUNT && awa_r != cmsl_pkg::REG_AUX)
            br_nxt = cmsl_pkg::RESP_SLVERR;
      end
      rv_nxt = rv_r && !s_axi_rready;
      rd_nxt = rd_r;
      rr_nxt = rr_r;
      if (s_axi_arvalid && !rv_r)
      begin
         rv_nxt = 1'b1;
         rr_nxt = cmsl_pkg::RESP_OKAY;
         unique case (s_axi_araddr[7:0])
            cmsl_pkg::REG_CTRL:   rd_nxt = {26'h0, ctrl_r};
            cmsl_pkg::REG_STATUS: rd_nxt = {22'h0, lines22_r, fast_r, busy_r, mode_r,
                                            1'b0, st_r};
            cmsl_pkg::REG_DATA:   rd_nxt = {24'h0, shf_r};
            cmsl_pkg::REG_COUNT:  rd_nxt = tot_r;
            cmsl_pkg::REG_AUX:    rd_nxt = {30'h0, aux_r, 1'b0};
            default:
            begin
               rd_nxt = 32'h0;
               rr_nxt = cmsl_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= ST_IDLE;       ctrl_r <= cmsl_pkg::CTRL_RESET;
         mode_r <= 3'h7;        addr_r <= 22'h0;
         shf_r <= 8'h0;         bcnt_r <= 4'h0;
         tot_r <= 32'h0;        fast_r <= 1'b0;
         lines22_r <= 1'b0;     busy_r <= 1'b0;
         ext_prev_r <= 1'b0;    wr_prev_r <= 1'b0;
         fwd_r <= 1'b1;         dout_r <= 1'b1;
         cbit_r <= 1'b0;        cval_r <= 1'b0;
         aux_r <= 1'b0;         hbyte_r <= 8'h0;
         aw_r <= 1'b0;          w_r <= 1'b0;
         awa_r <= 8'h0;         wd_r <= 32'h0;
         bv_r <= 1'b0;          br_r <= 2'h0;
         rv_r <= 1'b0;          rd_r <= 32'h0;
         rr_r <= 2'h0;          cko_r <= 1'b0;
         ckoe_r <= 1'b0;        aoe_r <= 1'b0;
         uoe_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;        ctrl_r <= ctrl_nxt;
         mode_r <= mode_nxt;    addr_r <= addr_nxt;
         shf_r <= shf_nxt;      bcnt_r <= bcnt_nxt;
         tot_r <= tot_nxt;      fast_r <= fast_nxt;
         lines22_r <= lines22_nxt;  busy_r <= busy_nxt;
         ext_prev_r <= ext_prev_nxt; wr_prev_r <= wr_prev_nxt;
         fwd_r <= fwd_nxt;      dout_r <= dout_nxt;
         cbit_r <= cbit_nxt;    cval_r <= cval_nxt;
         aux_r <= aux_nxt;      hbyte_r <= hbyte_nxt;
         aw_r <= aw_nxt;        w_r <= w_nxt;
         awa_r <= awa_nxt;      wd_r <= wd_nxt;
         bv_r <= bv_nxt;        br_r <= br_nxt;
         rv_r <= rv_nxt;        rd_r <= rd_nxt;
         rr_r <= rr_nxt;        cko_r <= cko_nxt;
         ckoe_r <= ckoe_nxt;    aoe_r <= aoe_nxt;
         uoe_r <= uoe_nxt;
      end
   end

   // Aux output pad only after load and when enabled
   logic aux_oe_r;
   logic aux_oe_nxt;
   always_comb
   begin
      aux_oe_nxt = (st_r == ST_DONE) && ctrl_r[cmsl_pkg::CTRL_AUXEN];
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         aux_oe_r <= 1'b0;
      else
         aux_oe_r <= aux_oe_nxt;
   end

   assign s_axi_awready         = aw_take;
   assign s_axi_wready          = w_take;
   assign s_axi_bvalid          = bv_r;
   assign s_axi_bresp           = br_r;
   assign s_axi_arready         = s_axi_arvalid && !rv_r;
   assign s_axi_rvalid          = rv_r;
   assign s_axi_rdata           = rd_r;
   assign s_axi_rresp           = rr_r;
   assign config_clock_out      = cko_r;
   assign config_clock_oe       = ckoe_r;
   assign serial_data_out       = dout_r;
   assign prom_address          = addr_r[17:0];
   assign upper_prom_address    = addr_r[21:18];
   assign prom_address_oe       = aoe_r;
   assign upper_prom_address_oe = uoe_r;
   assign ready_busy            = !busy_r;
   assign aux_output_pad        = aux_r;
   assign aux_output_oe         = aux_oe_r;
   assign config_bit            = cbit_r;
   assign config_bit_valid      = cval_r;
endmodule : cmsl_loader

//--- tb/cmsl_loader_assertions.sv
// Port-level checks for the configuration loader
`timescale 1ns/1ps
module cmsl_loader_assertions (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        config_clock_oe,
   input wire logic        prom_address_oe,
   input wire logic        upper_prom_address_oe,
   input wire logic        aux_output_oe,
   input wire logic        ready_busy,
   input wire logic        config_bit_valid
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_aw_no_pend: assert property (s_axi_awready |-> !s_axi_bvalid)
      else $error("write taken with response pending");
   a_ar_no_pend: assert property (s_axi_arready |-> !s_axi_rvalid)
      else $error("read taken with data pending");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_upper_lines: assert property (upper_prom_address_oe |-> prom_address_oe)
      else $error("upper address driven alone");
   a_aux_after: assert property (aux_output_oe |-> !config_clock_oe && !prom_address_oe)
      else $error("aux pad driven while loading");
   a_busy_serial: assert property ($fell(ready_busy) |-> ##[1:1000] config_bit_valid)
      else $error("busy without serialized bits");
   a_bit_pulse: assert property (config_bit_valid |=> !config_bit_valid)
      else $error("bit strobe longer than a cycle");
endmodule : cmsl_loader_assertions
bind cmsl_loader cmsl_loader_assertions i_chk (.*);

//--- tb/cmsl_prom_model.sv
// Behavioural PROM at the loader's far side
`timescale 1ns/1ps
module cmsl_prom_model (
   input  wire logic        aclk,
   input  wire logic [17:0] prom_address,
   input  wire logic [3:0]  upper_prom_address,
   input  wire logic        prom_address_oe,
   input  wire logic        config_clock_out,
   input  wire logic        config_clock_oe,
   output logic      [7:0]  prom_data,
   output logic             prom_ser
);
   logic       ck_r   = 1'b0;
   logic [7:0] lfsr_r = 8'hA7;
   initial prom_data = 8'h00;
   initial prom_ser = 1'b1;
   always @(posedge aclk)
   begin
      ck_r <= config_clock_out;
      // Released bus toggles every cycle between the last byte and its inverse
      if (prom_address_oe)
         prom_data <= prom_address[7:0] ^ {upper_prom_address, 4'h5};
      else
         prom_data <= ~prom_data;
      if (config_clock_oe && ck_r && !config_clock_out)
      begin
         lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5]};
         prom_ser <= lfsr_r[0];
      end
   end
endmodule : cmsl_prom_model

//--- tb/cmsl_loader_bench.sv
// Self-checking bench for the configuration loader
`timescale 1ns/1ps
module cmsl_loader_bench;
   logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, host_write_n = 1, ext_clk = 0, ext_run = 0;
   logic        mode_sel_bit2 = 1, mode_sel_bit1 = 1, mode_sel_bit0 = 1, tb_ser = 1, prom_ser;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        config_clock_out, config_clock_oe, serial_data_out, prom_address_oe;
   logic        upper_prom_address_oe, ready_busy, aux_output_pad, aux_output_oe;
   logic        config_bit, config_bit_valid, serial_data_in, config_clock_in;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd, ctrl;
   logic [3:0]  s_axi_wstrb = 4'hF, upper_prom_address;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [7:0]  prom_data, host_data = 0;
   logic [17:0] prom_address;
   logic [2:0]  m;
   logic [2:0]  modes [8] = '{3'h7, 3'h0, 3'h4, 3'h6, 3'h3, 3'h5, 3'h1, 3'h2};
   int          mismatches = 0, check_count = 0, cycles = 0, seed = 66, n;
   assign config_clock_in = ext_clk;
   assign serial_data_in = config_clock_oe ? prom_ser : tb_ser;
   cmsl_loader #(.FRAME_BITS(16), .LOAD_BITS(32'h0000_0020)) i_dut (.*);
   cmsl_prom_model i_prom (.*);
   always #50 aclk = ~aclk;
   initial
   begin
      #37;
      forever #400 if (ext_run) ext_clk = ~ext_clk;
   end
   always @(negedge ext_clk) tb_ser <= 1'($random(seed));
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         mismatches++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wait_sig(ref logic s, input logic v);
      for (n = 0; n < 3000 && s !== v; n++)
         @(negedge aclk);
      check(s, v);
   endtask : wait_sig
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      @(posedge aclk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(negedge aclk);
         aw = s_axi_awready;
         w = s_axi_wready;
         b = s_axi_bvalid;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      while (b !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      logic ar, r;
      @(posedge aclk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         ar = s_axi_arready;
         r = s_axi_rvalid;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      while (r !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   function automatic logic [22:0] start_addr(input logic [2:0] md, input logic [31:0] c);
      logic wide;
      wide = c[cmsl_pkg::CTRL_LINES22] | c[cmsl_pkg::CTRL_LOWV];
      return {wide, md == 3'h6 ? (wide ? 22'h3FFFFF : 22'h03FFFF) : 22'h000000};
   endfunction : start_addr
   initial
   begin
      repeat (6) @(posedge aclk);
      @(negedge aclk);
      check({ready_busy, serial_data_out, config_clock_oe, prom_address_oe}, 4'hC);
      aresetn <= 1'b1;
      axi_rd(cmsl_pkg::REG_CTRL);
      check(rd, 32'h0);
      axi_rd(8'h40);
      check(rs, cmsl_pkg::RESP_SLVERR);
      foreach (modes[i])
      begin
         m = modes[i];
         ctrl = 32'h1 | (32'($random(seed)) & 32'hE);
         {mode_sel_bit2, mode_sel_bit1, mode_sel_bit0} <= m;
         ext_run = (m == 3'h7 || m == 3'h3);
         repeat (4) @(posedge aclk);
         axi_wr(cmsl_pkg::REG_CTRL, ctrl);
         {mode_sel_bit2, mode_sel_bit1, mode_sel_bit0} <= ~m;
         axi_rd(cmsl_pkg::REG_STATUS);
         check(rd[8:4], {2'h0, m});
         if (m == 3'h4 || m == 3'h6)
         begin
            wait_sig(prom_address_oe, 1'b1);
            n = upper_prom_address_oe ? upper_prom_address : 4'h0;
            check({upper_prom_address_oe, 4'(n), prom_address}, start_addr(m, ctrl));
         end
         if (m == 3'h0)
            wait_sig(config_clock_oe, 1'b1);
         if (m == 3'h0 || m == 3'h7)
         begin
            wait_sig(config_bit_valid, 1'b1);
            check(config_bit, serial_data_in);
         end
         if (m == 3'h1 || m == 3'h2)
         begin
            repeat (40) @(negedge aclk);
            check({config_clock_oe, prom_address_oe}, 2'h0);
         end
         if (m == 3'h3 || m == 3'h5)
         begin
            host_data <= 8'($random(seed));
            host_write_n <= 1'b0;
            wait_sig(ready_busy, 1'b0);
            host_write_n <= 1'b1;
            wait_sig(ready_busy, 1'b1);
            axi_rd(cmsl_pkg::REG_DATA);
            check(rd[7:0], host_data);
         end
         axi_wr(cmsl_pkg::REG_CTRL, 32'h20);
         ext_run = 0;
         $display("mode %h done", m);
      end
      {mode_sel_bit2, mode_sel_bit1, mode_sel_bit0} <= 3'h0;
      repeat (4) @(posedge aclk);
      axi_wr(cmsl_pkg::REG_CTRL, 32'h13);
      {mode_sel_bit2, mode_sel_bit1, mode_sel_bit0} <= 3'h4;
      axi_wr(cmsl_pkg::REG_AUX, 32'h2);
      wait_sig(aux_output_oe, 1'b1);
      check(aux_output_pad, 1'b1);
      axi_rd(cmsl_pkg::REG_AUX);
      check(rd[1], 1'b1);
      $display("aux test done");
      stop_test();
   end
endmodule : cmsl_loader_bench
